// ---- logic/sss_params.svh ----
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// Clock period of clock_in
`define SSS_CLK_PERIOD_NS     10
// Initial delay after leaving shutdown
`define SSS_INIT_DELAY_NS     1100000
// Hold at boot level
`define SSS_BOOT_HOLD_NS      93000
// Delay from final code to good flag
`define SSS_GOOD_DELAY_NS     93000
// Latest settled code time into the hold, advisory for the processor
`define SSS_CODE_SETTLE_NS    50000
// Reference DAC: one step is 6.25 mV, boot level 1.1 V is 176 steps
`define SSS_DAC_W             8
`define SSS_BOOT_STEPS        8'hb0
`define SSS_DAC_ZERO          8'h00
// Codes below this value are treated as off codes
`define SSS_MIN_VALID_CODE    8'h02
// Phase counter width, covers the longest delay
`define SSS_CNT_W             17
`define SSS_CNT_ZERO          17'h00000
`define SSS_CNT_ONE           17'h00001
// Number of power phases
`define SSS_PHASES            3

`endif

// ---- logic/sss_pkg.sv ----
`include "sss_params.svh"

package sss_pkg;

   typedef enum logic [2:0] {
      SSS_SHUTDOWN,
      SSS_INIT_DELAY,
      SSS_FIRST_RAMP,
      SSS_BOOT_HOLD,
      SSS_SECOND_RAMP,
      SSS_GOOD_DELAY,
      SSS_RUN
   } sss_phase_t;

   typedef enum logic [1:0] {
      SSS_RAIL_NORMAL,
      SSS_RAIL_LOW_GND,
      SSS_RAIL_LOW_VCC
   } sss_rail_t;

   typedef struct packed {
      sss_phase_t                 phase;
      logic [`SSS_CNT_W-1:0]      cnt;
      logic [`SSS_DAC_W-1:0]      code;
      logic                       drives_on;
      logic                       good;
      sss_rail_t                  rail;
      logic [`SSS_PHASES-1:0]     high_side;
      logic [`SSS_PHASES-1:0]     low_side;
   } sss_top_state_t;

   typedef struct packed {
      logic [`SSS_DAC_W-1:0]      level;
   } sss_ramp_state_t;

endpackage

// ---- logic/sss_ramp.sv ----
`timescale 1ns/1ps
`include "sss_params.svh"

module sss_ramp (
   input  wire logic   clock_in,
   input  wire logic   sys_rst_in,
   sss_ramp_if.ramp    rif
);

   sss_pkg::sss_ramp_state_t st_r;
   sss_pkg::sss_ramp_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (rif.clear) begin
         st_nxt.level = `SSS_DAC_ZERO;
      end else if (rif.run && rif.tick && (st_r.level != rif.target)) begin
         if (st_r.level < rif.target) begin
            st_nxt.level = st_r.level + 8'h01;
         end else begin
            st_nxt.level = st_r.level - 8'h01;
         end
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rif.level   = st_r.level;
   assign rif.reached = (st_r.level == rif.target);

endmodule

// ---- logic/sss_ramp_if.sv ----
`timescale 1ns/1ps
`include "sss_params.svh"

interface sss_ramp_if;
   logic                       clear;
   logic                       run;
   logic                       tick;
   logic [`SSS_DAC_W-1:0]      target;
   logic [`SSS_DAC_W-1:0]      level;
   logic                       reached;

   modport ctrl (output clear, output run, output tick, output target, input level, input reached);
   modport ramp (input clear, input run, input tick, input target, output level, output reached);
endinterface

// ---- logic/sss_sequencer.sv ----
`timescale 1ns/1ps
`include "sss_params.svh"

module sss_sequencer #(
   parameter int unsigned INIT_DELAY_CYC =
      (`SSS_INIT_DELAY_NS + `SSS_CLK_PERIOD_NS - 1) / `SSS_CLK_PERIOD_NS,
   parameter int unsigned BOOT_HOLD_CYC  =
      (`SSS_BOOT_HOLD_NS + `SSS_CLK_PERIOD_NS - 1) / `SSS_CLK_PERIOD_NS,
   parameter int unsigned GOOD_DELAY_CYC =
      (`SSS_GOOD_DELAY_NS + `SSS_CLK_PERIOD_NS - 1) / `SSS_CLK_PERIOD_NS
) (
   input  wire logic                       clock_in,
   input  wire logic                       sys_rst_in,
   input  wire logic                       logic_por_ok_in,
   input  wire logic                       enable_ok_in,
   input  wire logic                       driver_por_ok_in,
   input  wire logic                       ss_tick_in,
   input  wire logic [`SSS_DAC_W-1:0]      target_voltage_code_in,
   input  wire logic                       feedback_node_above_ref_in,
   input  wire logic [`SSS_PHASES-1:0]     pwm_in,
   input  wire logic                       low_power_state_n_in,
   input  wire logic                       strap_to_supply_in,
   output logic [`SSS_PHASES-1:0]          high_side_drive_out,
   output logic [`SSS_PHASES-1:0]          low_side_drive_out,
   output logic [`SSS_DAC_W-1:0]           dac_level_out,
   output logic                            output_good_flag_out,
   output logic [1:0]                      ch1_low_drive_rail_out,
   output logic [2:0]                      phase_out
);

   localparam logic [`SSS_CNT_W-1:0] INIT_LAST = `SSS_CNT_W'(INIT_DELAY_CYC - 1);
   localparam logic [`SSS_CNT_W-1:0] HOLD_LAST = `SSS_CNT_W'(BOOT_HOLD_CYC - 1);
   localparam logic [`SSS_CNT_W-1:0] GOOD_LAST = `SSS_CNT_W'(GOOD_DELAY_CYC - 1);

   sss_pkg::sss_top_state_t st_r;
   sss_pkg::sss_top_state_t st_nxt;

   sss_ramp_if rif ();

   logic start_ok;
   logic in_ramp;
   logic code_valid;

   sss_ramp u_ramp (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .rif        (rif.ramp)
   );

   assign start_ok   = logic_por_ok_in & enable_ok_in & driver_por_ok_in;
   assign in_ramp    = (st_r.phase == sss_pkg::SSS_FIRST_RAMP) || (st_r.phase == sss_pkg::SSS_SECOND_RAMP);
   assign code_valid = (target_voltage_code_in >= `SSS_MIN_VALID_CODE);

   assign rif.tick   = ss_tick_in;
   assign rif.run    = in_ramp;
   assign rif.clear  = (st_r.phase == sss_pkg::SSS_SHUTDOWN) || (st_r.phase == sss_pkg::SSS_INIT_DELAY);
   // first ramp aims at boot level
   assign rif.target = (st_r.phase == sss_pkg::SSS_FIRST_RAMP) ? `SSS_BOOT_STEPS : st_r.code;

   always_comb begin
      st_nxt = st_r;

      if (low_power_state_n_in) begin
         st_nxt.rail = sss_pkg::SSS_RAIL_NORMAL;
      end else if (strap_to_supply_in) begin
         st_nxt.rail = sss_pkg::SSS_RAIL_LOW_VCC;
      end else begin
         st_nxt.rail = sss_pkg::SSS_RAIL_LOW_GND;
      end

      if (!start_ok) begin
         st_nxt.phase     = sss_pkg::SSS_SHUTDOWN;
         st_nxt.cnt       = `SSS_CNT_ZERO;
         st_nxt.drives_on = 1'b0;
         st_nxt.good      = 1'b0;
      end else begin
         unique case (st_r.phase)
            sss_pkg::SSS_SHUTDOWN: begin
               st_nxt.phase     = sss_pkg::SSS_INIT_DELAY;
               st_nxt.cnt       = `SSS_CNT_ZERO;
               st_nxt.drives_on = 1'b0;
               st_nxt.good      = 1'b0;
            end
            sss_pkg::SSS_INIT_DELAY: begin
               if (st_r.cnt == INIT_LAST) begin
                  st_nxt.phase = sss_pkg::SSS_FIRST_RAMP;
                  st_nxt.cnt   = `SSS_CNT_ZERO;
               end else begin
                  st_nxt.cnt = st_r.cnt + `SSS_CNT_ONE;
               end
            end
            sss_pkg::SSS_FIRST_RAMP: begin
               if (rif.reached) begin
                  st_nxt.phase = sss_pkg::SSS_BOOT_HOLD;
                  st_nxt.cnt   = `SSS_CNT_ZERO;
               end
            end
            sss_pkg::SSS_BOOT_HOLD: begin
               if (st_r.cnt == HOLD_LAST) begin
                  if (code_valid) begin
                     st_nxt.code  = target_voltage_code_in;
                     st_nxt.phase = sss_pkg::SSS_SECOND_RAMP;
                     st_nxt.cnt   = `SSS_CNT_ZERO;
                  end
               end else begin
                  st_nxt.cnt = st_r.cnt + `SSS_CNT_ONE;
               end
            end
            sss_pkg::SSS_SECOND_RAMP: begin
               if (rif.reached) begin
                  st_nxt.phase     = sss_pkg::SSS_GOOD_DELAY;
                  st_nxt.cnt       = `SSS_CNT_ZERO;
                  st_nxt.drives_on = 1'b1;
               end
            end
            sss_pkg::SSS_GOOD_DELAY: begin
               if (st_r.cnt == GOOD_LAST) begin
                  st_nxt.phase = sss_pkg::SSS_RUN;
                  st_nxt.good  = 1'b1;
               end else begin
                  st_nxt.cnt = st_r.cnt + `SSS_CNT_ONE;
               end
            end
            sss_pkg::SSS_RUN: begin
               st_nxt.good = 1'b1;
            end
            default: begin
               st_nxt.phase = sss_pkg::SSS_SHUTDOWN;
            end
         endcase

         if ((in_ramp || st_r.phase == sss_pkg::SSS_BOOT_HOLD) && !feedback_node_above_ref_in) begin
            st_nxt.drives_on = 1'b1;
         end
      end

      st_nxt.high_side = {`SSS_PHASES{st_nxt.drives_on}} & pwm_in;
      st_nxt.low_side  = {`SSS_PHASES{st_nxt.drives_on}} & ~pwm_in;
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign high_side_drive_out    = st_r.high_side;
   assign low_side_drive_out     = st_r.low_side;
   assign dac_level_out          = rif.level;
   assign output_good_flag_out   = st_r.good;
   assign ch1_low_drive_rail_out = st_r.rail;
   assign phase_out              = st_r.phase;

endmodule

// ---- verif/sss_cpu_model.sv ----
`timescale 1ns/1ps
module sss_cpu_model (
   input  wire logic       clock_in,
   input  wire logic [2:0] phase_in,
   input  wire logic [7:0] want_in,
   input  wire logic       bad_in,
   output logic      [7:0] code_out,
   output logic            low_power_state_n_out
);
   logic [7:0] cnt_r = 8'h00;
   always @(posedge clock_in) cnt_r <= cnt_r + 8'h01;
   assign code_out = phase_in < 3'h3 ? cnt_r ^ 8'h5a : bad_in ? 8'h01 : want_in;
   assign low_power_state_n_out = cnt_r[4];
endmodule

// ---- verif/sss_sequencer_props.sv ----
`timescale 1ns/1ps
module sss_sequencer_props #(
   parameter int INIT_DELAY_CYC = 20,
   parameter int BOOT_HOLD_CYC  = 10,
   parameter int GOOD_DELAY_CYC = 10
) (
   input wire logic       clock_in,
   input wire logic       sys_rst_in,
   input wire logic       logic_por_ok_in,
   input wire logic       enable_ok_in,
   input wire logic       driver_por_ok_in,
   input wire logic       ss_tick_in,
   input wire logic       low_power_state_n_in,
   input wire logic       strap_to_supply_in,
   input wire logic [2:0] high_side_drive_out,
   input wire logic [2:0] low_side_drive_out,
   input wire logic [7:0] dac_level_out,
   input wire logic       output_good_flag_out,
   input wire logic [1:0] ch1_low_drive_rail_out,
   input wire logic [2:0] phase_out
);
   wire all_ok = logic_por_ok_in & enable_ok_in & driver_por_ok_in;
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   gates_held_a: assert property (phase_out <= 3'h1 |-> {high_side_drive_out, low_side_drive_out} == 6'h00)
      else $error("gate on while held off");
   start_wait_a: assert property (phase_out == 3'h0 && !all_ok |=> phase_out == 3'h0)
      else $error("left shutdown early");
   start_go_a: assert property (phase_out == 3'h0 && all_ok |=> phase_out == 3'h1)
      else $error("start not taken");
   loss_stop_a: assert property (!all_ok |=> phase_out == 3'h0 && !output_good_flag_out)
      else $error("no shutdown on loss");
   good_run_a: assert property (output_good_flag_out |-> phase_out == 3'h6)
      else $error("good flag early");
   init_len_a: assert property (disable iff (sys_rst_in || !all_ok)
      phase_out == 3'h1 && $past(phase_out) == 3'h0 |-> ##INIT_DELAY_CYC phase_out == 3'h2)
      else $error("initial delay length");
   good_len_a: assert property (disable iff (sys_rst_in || !all_ok)
      phase_out == 3'h5 && $past(phase_out) == 3'h4 |-> ##GOOD_DELAY_CYC output_good_flag_out)
      else $error("good delay length");
   ramp_step_a: assert property (disable iff (sys_rst_in || !all_ok)
      phase_out == 3'h2 && dac_level_out < 8'hb0 |=> dac_level_out == $past(dac_level_out) + {7'h0, $past(ss_tick_in)})
      else $error("ramp step wrong");
   boot_hold_a: assert property (phase_out == 3'h3 |-> dac_level_out == 8'hb0)
      else $error("hold level wrong");
   rail_sel_a: assert property (!$past(sys_rst_in) |=> ch1_low_drive_rail_out ==
      ($past(low_power_state_n_in) ? 2'h0 : $past(strap_to_supply_in) ? 2'h2 : 2'h1))
      else $error("rail level wrong");
endmodule
bind sss_sequencer sss_sequencer_props #(.INIT_DELAY_CYC(INIT_DELAY_CYC), .BOOT_HOLD_CYC(BOOT_HOLD_CYC),
   .GOOD_DELAY_CYC(GOOD_DELAY_CYC)) u_sss_sequencer_props (.clock_in, .sys_rst_in, .logic_por_ok_in,
   .enable_ok_in, .driver_por_ok_in, .ss_tick_in, .low_power_state_n_in, .strap_to_supply_in,
   .high_side_drive_out, .low_side_drive_out, .dac_level_out, .output_good_flag_out, .ch1_low_drive_rail_out,
   .phase_out);

// ---- verif/sss_sequencer_test.sv ----
`timescale 1ns/1ps
module sss_sequencer_test;
   logic       clock_in = 0, sys_rst_in = 1, tick = 0, fb = 1, strap = 0, bad = 0, good_q = 0, good, lps_n;
   logic [2:0] ok = 3'h0, pwm = 3'h0, pwm_q = 3'h0, hs, ls, ph;
   logic [7:0] code, dac, want = 8'hc8;
   logic [1:0] rail;
   int         n_fail = 0, samples_checked = 0, cyc = 0, seed = 22136;
   logic [7:0] exp_q[$];
   logic [1:0] rail_q[$];
   logic       rst_q = 1;

   always #5 clock_in = ~clock_in;

   sss_sequencer #(.INIT_DELAY_CYC(20), .BOOT_HOLD_CYC(10), .GOOD_DELAY_CYC(10)) u_sss_sequencer (
      .clock_in, .sys_rst_in, .logic_por_ok_in(ok[2]), .enable_ok_in(ok[1]), .driver_por_ok_in(ok[0]),
      .ss_tick_in(tick), .target_voltage_code_in(code), .feedback_node_above_ref_in(fb), .pwm_in(pwm),
      .low_power_state_n_in(lps_n), .strap_to_supply_in(strap), .high_side_drive_out(hs),
      .low_side_drive_out(ls), .dac_level_out(dac), .output_good_flag_out(good),
      .ch1_low_drive_rail_out(rail), .phase_out(ph));
   sss_cpu_model u_sss_cpu_model (.clock_in, .phase_in(ph), .want_in(want), .bad_in(bad),
      .code_out(code), .low_power_state_n_out(lps_n));

   task automatic check(string nm, logic [7:0] e, logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wait_phase(logic [2:0] p);
      int k;
      k = 0;
      while (ph !== p && k < 2000) begin
         @(posedge clock_in);
         k++;
      end
      check("phase", {5'h0, p}, {5'h0, ph});
   endtask

   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      tick <= ~tick & 1'($random(seed));
      pwm <= 3'($random(seed));
      strap <= 1'($random(seed));
      pwm_q <= pwm;
      if (!sys_rst_in) rail_q.push_back(lps_n ? 2'h0 : strap ? 2'h2 : 2'h1);
      if (cyc == 4000) begin
         n_fail++;
         give_verdict();
      end
   end

   // Result watcher
   always @(posedge clock_in) begin
      good_q <= good;
      rst_q <= sys_rst_in;
      if (!rst_q) check("rail", {6'h0, rail_q.pop_front()}, {6'h0, rail});
      if (good && !good_q) begin
         check("final level", exp_q.pop_front(), dac);
         check("gates", {2'h0, pwm_q, ~pwm_q}, {2'h0, hs, ls});
      end
   end

   initial begin
      repeat (3) @(posedge clock_in);
      sys_rst_in <= 0;
      for (int i = 0; i < 3; i++) begin
         ok <= ~(3'h1 << i);
         repeat (3) @(posedge clock_in);
         check("held", 8'h00, {2'h0, hs, ls});
         check("phase", 8'h00, {5'h0, ph});
      end
      $display("test start gating done");
      exp_q.push_back(want);
      ok <= 3'h7;
      wait_phase(3'h2);
      repeat (40) @(posedge clock_in);
      check("biased", 8'h00, {2'h0, hs, ls});
      fb <= 0;
      wait_phase(3'h3);
      check("boot", 8'hb0, dac);
      check("track", {2'h0, pwm_q, ~pwm_q}, {2'h0, hs, ls});
      wait_phase(3'h6);
      $display("test prebiased start done");
      ok <= 3'h5;
      repeat (2) @(posedge clock_in);
      check("dropped", 8'h00, {good, 1'h0, ph, hs});
      want <= 8'h02 + 8'($random(seed) & 32'h7f);
      bad <= 1;
      fb <= 1;
      ok <= 3'h7;
      wait_phase(3'h3);
      repeat (30) @(posedge clock_in);
      check("refused", 8'h03, {5'h0, ph});
      exp_q.push_back(want);
      bad <= 0;
      wait_phase(3'h6);
      $display("test restart low code done");
      give_verdict();
   end
endmodule
